// ===== hdl/sfs_pkg.sv
// Constants and types of the boot flash sequencer.
// Assumes a 100 MHz system clock; used by the shifter and the top level of the block.
package sfs_pkg;
    // Clock rates and timing
    localparam int SYS_CLK_KHZ   = 100000;
    localparam int SPI_MAX_KHZ   = 36000;
    localparam int SCLK_HALF_MIN = (SYS_CLK_KHZ + 2 * SPI_MAX_KHZ - 1) / (2 * SPI_MAX_KHZ);
    localparam int SYNC_MARGIN   = 1;
    localparam int CS_GAP_NS     = 200;
    localparam int CS_GAP_CYCLES = (CS_GAP_NS * (SYS_CLK_KHZ / 1000) + 999) / 1000;
    localparam int BYTE_BITS     = 8;

    // Flash opcodes
    localparam logic [7:0] OPC_FAST_READ    = 8'h0b;
    localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_WRITE_LATCH  = 8'h06;
    localparam logic [7:0] OPC_PAGE_PROG    = 8'h02;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OPC_CHIP_ERASE   = 8'hc7;
    localparam logic [7:0] PROTECT_CLEAR    = 8'h00;
    localparam logic [7:0] FILL_BYTE        = 8'h00;

    // Status byte fields
    localparam int BUSY_BIT  = 0;
    localparam int LATCH_BIT = 1;

    // Frame layout, counted in bytes
    localparam int ADDR_IDX_HI = 1;
    localparam int ADDR_IDX_MD = 2;
    localparam int ADDR_IDX_LO = 3;
    localparam int PROG_HDR    = 4;
    localparam int READ_HDR    = 5;
    localparam int STATUS_IDX  = 1;

    typedef enum logic [2:0] {
        SFS_OP_READ,
        SFS_OP_PROGRAM,
        SFS_OP_SECTOR_ERASE,
        SFS_OP_CHIP_ERASE,
        SFS_OP_PMIC
    } sfs_op_type;
endpackage : sfs_pkg

// ===== hdl/sfs_byte_if.sv
// Byte exchange carrier between the sequencer and the serial shifter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface sfs_byte_if;
    logic       start;
    logic [7:0] tx;
    logic       done;
    logic [7:0] rx;
    modport master  (output start, output tx, input done, input rx);
    modport shifter (input start, input tx, output done, output rx);
endinterface : sfs_byte_if
`default_nettype wire

// ===== hdl/sfs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sfs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;
    assign out_data_o  = mem[rd_ptr];

    // Storage
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sfs_fifo
`default_nettype wire

// ===== hdl/sfs_shifter.sv
// Mode 0 serial byte shifter, most significant bit first.
// Assumes the sequencer holds the select; the data input pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sfs_shifter #(
    parameter int HALF = sfs_pkg::SCLK_HALF_MIN + sfs_pkg::SYNC_MARGIN
) (
    input  wire logic   sys_clk_i,
    input  wire logic   rst_i,
    sfs_byte_if.shifter bus,
    output logic        serial_clk_out_o,
    output logic        serial_data_out_o,
    input  wire logic   serial_data_in_i
);
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

    logic          din_meta;
    logic          din_sync;
    logic          active;
    logic [CW-1:0] phase_cnt;
    logic [2:0]    bit_cnt;
    logic [7:0]    shreg;

    assign bus.rx = shreg;

    // Input synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end else begin
            din_meta <= serial_data_in_i;
            din_sync <= din_meta;
        end
    end

    // Bit engine
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            active            <= 1'b0;
            phase_cnt         <= '0;
            bit_cnt           <= '0;
            shreg             <= '0;
            serial_clk_out_o  <= 1'b0;
            serial_data_out_o <= 1'b0;
            bus.done          <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            if (!active) begin
                if (bus.start) begin
                    active            <= 1'b1;
                    shreg             <= bus.tx;
                    serial_data_out_o <= bus.tx[7]; // RQ25
                    bit_cnt           <= 3'(sfs_pkg::BYTE_BITS - 1);
                    phase_cnt         <= CW'(HALF - 1);
                end
            end else if (phase_cnt != '0) begin
                phase_cnt <= phase_cnt - 1'b1;
            end else begin
                phase_cnt <= CW'(HALF - 1);
                if (!serial_clk_out_o) begin
                    serial_clk_out_o <= 1'b1;
                end else begin
                    serial_clk_out_o  <= 1'b0;
                    shreg             <= {shreg[6:0], din_sync};
                    serial_data_out_o <= shreg[6];
                    if (bit_cnt == '0) begin
                        active   <= 1'b0;
                        bus.done <= 1'b1;
                    end else begin
                        bit_cnt <= bit_cnt - 1'b1;
                    end
                end
            end
        end
    end
endmodule : sfs_shifter
`default_nettype wire

// ===== hdl/sfs_top.sv
// Boot flash sequencer: boot unprotect and fetch, then host flash commands.
// Assumes a mode 0 serial flash on select zero and a second target on select one.
//
// Behaviour
// RQ1 - Every boot assumes the flash is protected and always clears protection.
// RQ2 - Protection clearing starts with a write-latch request before any status write.
// RQ3 - After that request, status reads repeat until the write latch flag is set.
// RQ4 - Then one status write sends a single all-zero byte.
// RQ5 - Each program or erase is preceded by latch request and latch polling.
// RQ6 - Program or erase opcode goes out only after the latch flag was seen.
// RQ7 - The flash clears its latch itself after each program or erase.
// RQ8 - No identity read; protocol and clock rate are fixed.
// RQ9 - Fast read: 0x0b, three address bytes, one dummy, then streaming data.
// RQ10 - Latch request is the lone byte 0x06; status read is 0x05 plus one byte.
// RQ11 - Status write is 0x01 with exactly one status byte, never two.
// RQ12 - Page program: 0x02, three address bytes, then the data bytes.
// RQ13 - Sector erase is 0x20 plus three address bytes; chip erase is 0xc7 alone.
// RQ14 - Flash hold and write-protect inputs are tied high outside, never driven.
// RQ15 - During reset the clock, data out and flash select pins are released.
// RQ16 - The second target select stays driven during reset.
// RQ17 - The host may program and erase the flash through the command port.
// RQ18 - One shared clock and data bus serves flash and power chip, up to 36 MHz.
// RQ19 - Each select drives only its own target.
// RQ20 - The flash must offer 4 KB sector erase.
// RQ21 - Boot data is fetched only through select zero.
// RQ22 - Attention is high during boot initialisation, low after; commands wait for that.
// RQ23 - Status bit 0 reports busy, bit 1 reports the write latch.
// RQ24 - After program or erase, status reads repeat until busy clears.
// RQ25 - Select falls before the opcode, rises after the last byte; MSB first.
`timescale 1ns/1ps
`default_nettype none
module sfs_top #(
    parameter int          LEN_W      = 16,
    parameter int          FIFO_DEPTH = 8,
    parameter int          SCLK_HALF  = sfs_pkg::SCLK_HALF_MIN + sfs_pkg::SYNC_MARGIN,
    parameter logic [23:0] BOOT_ADDR  = 24'h000000,
    parameter int          BOOT_BYTES = 256
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cmd_valid_i,
    output logic                      cmd_ready_o,
    input  wire sfs_pkg::sfs_op_type  cmd_op_i,
    input  wire logic [23:0]          cmd_addr_i,
    input  wire logic [LEN_W-1:0]     cmd_len_i,
    input  wire logic [7:0]           wr_data_i,
    input  wire logic                 wr_valid_i,
    output logic                      wr_ready_o,
    output logic [7:0]                rd_data_o,
    output logic                      rd_valid_o,
    output logic                      rd_boot_o,
    output logic [7:0]                pmic_rx_o,
    output logic                      pmic_rx_valid_o,
    output logic [7:0]                status_o,
    output logic                      host_attn_o,
    output logic                      serial_clk_out_o,
    output logic                      serial_clk_out_oe_o,
    output logic                      serial_data_out_o,
    output logic                      serial_data_out_oe_o,
    output logic                      boot_flash_select_n_o,
    output logic                      boot_flash_select_n_oe_o,
    output logic                      second_target_select_n_o,
    input  wire logic                 serial_data_in_i
);
    typedef enum logic [3:0] {
        S_BOOT_LATCH,
        S_BOOT_POLL_LATCH,
        S_BOOT_UNPROTECT,
        S_BOOT_POLL_BUSY,
        S_BOOT_READ,
        S_IDLE,
        S_LATCH,
        S_POLL_LATCH,
        S_MODIFY,
        S_POLL_BUSY,
        S_READ,
        S_PMIC
    } sfs_state_type;

    localparam int IW = LEN_W + 1;
    localparam int GW = $clog2(sfs_pkg::CS_GAP_CYCLES + 1);

    sfs_byte_if          bus ();
    sfs_state_type       state;
    sfs_pkg::sfs_op_type op;
    logic [23:0]         addr;
    logic [LEN_W-1:0]    len;
    logic                in_frame;
    logic                want;
    logic                frame_done;
    logic [GW-1:0]       gap_cnt;
    logic [IW-1:0]       idx;
    logic [IW-1:0]       last_idx;
    logic [7:0]          tx_byte;
    logic                pin_oe;
    logic                prog_data;
    logic                can_send;
    logic                needs_frame;
    logic                is_poll;
    logic                is_read;
    logic                fifo_valid;
    logic [7:0]          fifo_data;
    logic                fifo_pop;

    sfs_shifter #(
        .HALF(SCLK_HALF)
    ) u_shifter (
        .sys_clk_i         (sys_clk_i),
        .rst_i             (rst_i),
        .bus               (bus.shifter),
        .serial_clk_out_o  (serial_clk_out_o),
        .serial_data_out_o (serial_data_out_o),
        .serial_data_in_i  (serial_data_in_i)
    );

    sfs_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .in_data_i   (wr_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    assign cmd_ready_o = (state == S_IDLE) && !host_attn_o; // RQ22
    assign is_poll     = (state == S_BOOT_POLL_LATCH) || (state == S_BOOT_POLL_BUSY) ||
                         (state == S_POLL_LATCH) || (state == S_POLL_BUSY);
    assign is_read     = (state == S_BOOT_READ) || (state == S_READ);
    assign needs_frame = (state != S_IDLE);
    assign prog_data   = (state == S_MODIFY) && (op == sfs_pkg::SFS_OP_PROGRAM) &&
                         (idx >= IW'(sfs_pkg::PROG_HDR));
    assign can_send    = !prog_data || fifo_valid;
    assign fifo_pop    = bus.start && prog_data;
    assign bus.tx      = tx_byte;

    // Pin drivers released while reset holds
    assign serial_clk_out_oe_o      = pin_oe; // RQ15
    assign serial_data_out_oe_o     = pin_oe; // RQ15
    assign boot_flash_select_n_oe_o = pin_oe; // RQ15

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= 1'b1;
        end
    end

    // Index of the last byte of the current frame
    always_comb begin
        last_idx = '0;
        case (state)
            S_BOOT_POLL_LATCH, S_BOOT_POLL_BUSY,
            S_POLL_LATCH, S_POLL_BUSY: last_idx = IW'(sfs_pkg::STATUS_IDX); // RQ10
            S_BOOT_UNPROTECT:          last_idx = IW'(sfs_pkg::STATUS_IDX); // RQ11
            S_BOOT_READ:               last_idx = IW'(sfs_pkg::READ_HDR + BOOT_BYTES - 1);
            S_READ:                    last_idx = IW'(sfs_pkg::READ_HDR - 1) + IW'(len);
            S_MODIFY: begin
                case (op)
                    sfs_pkg::SFS_OP_PROGRAM:      last_idx = IW'(sfs_pkg::PROG_HDR - 1) + IW'(len);
                    sfs_pkg::SFS_OP_SECTOR_ERASE: last_idx = IW'(sfs_pkg::ADDR_IDX_LO); // RQ13
                    default:                      last_idx = '0;
                endcase
            end
            default:                   last_idx = '0;
        endcase
    end

    // Byte to send at the current index
    always_comb begin
        logic [7:0] opc;
        logic [23:0] a;
        opc = sfs_pkg::FILL_BYTE;
        a   = (state == S_BOOT_READ) ? BOOT_ADDR : addr; // RQ21
        case (state)
            S_BOOT_LATCH, S_LATCH:      opc = sfs_pkg::OPC_WRITE_LATCH; // RQ2 RQ5 RQ10
            S_BOOT_POLL_LATCH, S_BOOT_POLL_BUSY,
            S_POLL_LATCH, S_POLL_BUSY:  opc = sfs_pkg::OPC_STATUS_READ; // RQ10
            S_BOOT_UNPROTECT:           opc = sfs_pkg::OPC_STATUS_WRITE; // RQ11
            S_BOOT_READ, S_READ:        opc = sfs_pkg::OPC_FAST_READ; // RQ9
            S_PMIC:                     opc = addr[7:0];
            S_MODIFY: begin
                case (op)
                    sfs_pkg::SFS_OP_PROGRAM:      opc = sfs_pkg::OPC_PAGE_PROG; // RQ12
                    sfs_pkg::SFS_OP_SECTOR_ERASE: opc = sfs_pkg::OPC_SECTOR_ERASE; // RQ13
                    default:                      opc = sfs_pkg::OPC_CHIP_ERASE; // RQ13
                endcase
            end
            default:                    opc = sfs_pkg::FILL_BYTE;
        endcase
        if (idx == '0) begin
            tx_byte = opc;
        end else if (state == S_BOOT_UNPROTECT) begin
            tx_byte = sfs_pkg::PROTECT_CLEAR; // RQ4
        end else if (is_poll) begin
            tx_byte = sfs_pkg::FILL_BYTE;
        end else if (idx == IW'(sfs_pkg::ADDR_IDX_HI)) begin
            tx_byte = a[23:16];
        end else if (idx == IW'(sfs_pkg::ADDR_IDX_MD)) begin
            tx_byte = a[15:8];
        end else if (idx == IW'(sfs_pkg::ADDR_IDX_LO)) begin
            tx_byte = a[7:0];
        end else if (prog_data) begin
            tx_byte = fifo_data; // RQ12
        end else begin
            tx_byte = sfs_pkg::FILL_BYTE; // RQ9
        end
    end

    // Frame engine: select, byte launches, deselect gap
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            in_frame                 <= 1'b0;
            want                     <= 1'b0;
            frame_done               <= 1'b0;
            gap_cnt                  <= GW'(sfs_pkg::CS_GAP_CYCLES);
            idx                      <= '0;
            bus.start                <= 1'b0;
            boot_flash_select_n_o    <= 1'b1;
            second_target_select_n_o <= 1'b1; // RQ16
        end else begin
            frame_done <= 1'b0;
            bus.start  <= 1'b0;
            if (!in_frame) begin
                if (gap_cnt != '0) begin
                    gap_cnt <= gap_cnt - 1'b1;
                end else if (needs_frame && !frame_done) begin
                    in_frame                 <= 1'b1;
                    want                     <= 1'b1;
                    idx                      <= '0;
                    boot_flash_select_n_o    <= (state == S_PMIC); // RQ19 RQ25
                    second_target_select_n_o <= (state != S_PMIC); // RQ19 RQ25
                end
            end else if (want && can_send) begin
                want      <= 1'b0;
                bus.start <= 1'b1; // RQ18
            end else if (bus.done) begin
                if (idx == last_idx) begin
                    in_frame                 <= 1'b0;
                    frame_done               <= 1'b1;
                    gap_cnt                  <= GW'(sfs_pkg::CS_GAP_CYCLES);
                    boot_flash_select_n_o    <= 1'b1; // RQ25
                    second_target_select_n_o <= 1'b1; // RQ25
                end else begin
                    idx  <= idx + 1'b1;
                    want <= 1'b1;
                end
            end
        end
    end

    // Received bytes: status, read stream, second target answer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            status_o        <= '0;
            rd_data_o       <= '0;
            rd_valid_o      <= 1'b0;
            rd_boot_o       <= 1'b0;
            pmic_rx_o       <= '0;
            pmic_rx_valid_o <= 1'b0;
        end else begin
            rd_valid_o      <= 1'b0;
            pmic_rx_valid_o <= 1'b0;
            if (bus.done && in_frame) begin
                if (is_poll && idx == IW'(sfs_pkg::STATUS_IDX)) begin
                    status_o <= bus.rx; // RQ23
                end
                if (is_read && idx >= IW'(sfs_pkg::READ_HDR)) begin
                    rd_data_o  <= bus.rx; // RQ9
                    rd_valid_o <= 1'b1;
                    rd_boot_o  <= (state == S_BOOT_READ);
                end
                if (state == S_PMIC) begin
                    pmic_rx_o       <= bus.rx;
                    pmic_rx_valid_o <= 1'b1;
                end
            end
        end
    end

    // Command latch
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            op   <= sfs_pkg::SFS_OP_READ;
            addr <= '0;
            len  <= '0;
        end else if (cmd_valid_i && cmd_ready_o) begin
            op   <= cmd_op_i;
            addr <= cmd_addr_i;
            len  <= cmd_len_i;
        end
    end

    // Attention to host during boot initialisation
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            host_attn_o <= 1'b1;
        end else if (state == S_BOOT_READ && frame_done) begin
            host_attn_o <= 1'b0; // RQ22
        end
    end

    // Sequence control; no identity read anywhere
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= S_BOOT_LATCH; // RQ1 RQ8
        end else begin
            case (state)
                S_BOOT_LATCH: begin
                    if (frame_done) begin
                        state <= S_BOOT_POLL_LATCH; // RQ2
                    end
                end
                S_BOOT_POLL_LATCH: begin
                    if (frame_done && status_o[sfs_pkg::LATCH_BIT]) begin
                        state <= S_BOOT_UNPROTECT; // RQ3
                    end
                end
                S_BOOT_UNPROTECT: begin
                    if (frame_done) begin
                        state <= S_BOOT_POLL_BUSY;
                    end
                end
                S_BOOT_POLL_BUSY: begin
                    if (frame_done && !status_o[sfs_pkg::BUSY_BIT]) begin
                        state <= S_BOOT_READ; // RQ24
                    end
                end
                S_BOOT_READ: begin
                    if (frame_done) begin
                        state <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (cmd_valid_i && cmd_ready_o) begin
                        case (cmd_op_i)
                            sfs_pkg::SFS_OP_READ: state <= S_READ;
                            sfs_pkg::SFS_OP_PMIC: state <= S_PMIC;
                            default:              state <= S_LATCH; // RQ5 RQ17
                        endcase
                    end
                end
                S_LATCH: begin
                    if (frame_done) begin
                        state <= S_POLL_LATCH; // RQ5 RQ7
                    end
                end
                S_POLL_LATCH: begin
                    if (frame_done && status_o[sfs_pkg::LATCH_BIT]) begin
                        state <= S_MODIFY; // RQ6
                    end
                end
                S_MODIFY: begin
                    if (frame_done) begin
                        state <= S_POLL_BUSY;
                    end
                end
                S_POLL_BUSY: begin
                    if (frame_done && !status_o[sfs_pkg::BUSY_BIT]) begin
                        state <= S_IDLE; // RQ24
                    end
                end
                S_READ, S_PMIC: begin
                    if (frame_done) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule : sfs_top
`default_nettype wire

// ===== tb/sfs_checker.sv
// Port checks of the boot flash sequencer.
// Assumes default timing parameters of sfs_top.
`timescale 1ns/1ps
`default_nettype none
module sfs_checker (
    input wire logic sys_clk_i, rst_i, cmd_ready_o, host_attn_o, pmic_rx_valid_o,
    input wire logic serial_clk_out_o, serial_clk_out_oe_o, serial_data_out_oe_o,
    input wire logic boot_flash_select_n_o, boot_flash_select_n_oe_o, second_target_select_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    pins_released_a: assert property ($fell(rst_i) |-> !serial_clk_out_oe_o
        && !boot_flash_select_n_oe_o && second_target_select_n_o) else $error("pins in reset");
    pins_driven_a: assert property ($fell(rst_i) |=> serial_data_out_oe_o
        && boot_flash_select_n_oe_o) else $error("pins not driven");
    boot_attn_a: assert property ($fell(rst_i) |-> host_attn_o) else $error("attn low");
    cmd_gate_a: assert property (host_attn_o |-> !cmd_ready_o) else $error("early ready");
    one_select_a: assert property (boot_flash_select_n_o || second_target_select_n_o)
        else $error("two selects");
    clock_framed_a: assert property (serial_clk_out_o |-> !boot_flash_select_n_o
        || !second_target_select_n_o) else $error("clock unframed");
    clock_rate_a: assert property ($rose(serial_clk_out_o) |=> serial_clk_out_o[*2]
        ##1 !serial_clk_out_o) else $error("clock high time");
    deselect_gap_a: assert property ($rose(boot_flash_select_n_o)
        |=> boot_flash_select_n_o[*8]) else $error("short gap");
    pmic_target_a: assert property (pmic_rx_valid_o |-> boot_flash_select_n_o)
        else $error("flash selected");
endmodule : sfs_checker
bind sfs_top sfs_checker u_sfs_checker (.*);
`default_nettype wire

// ===== tb/sfs_flash_model.sv
// Behavioural mode 0 serial flash.
// Assumes select high while the pins are released.
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_model (
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic mosi_i,
    output logic      miso_o
);
    logic [7:0]  op = 0, sh = 0, st = 0, wsr = 8'hff, b;
    logic [15:0] sig = 0;
    int          n = 0, bad = 0;
    wire         hold_n = 1'b1;
    initial miso_o = 1'b0;
    always @(negedge cs_n_i) n = 0;
    always @(posedge sclk_i) if (!cs_n_i && hold_n) begin
        sh = {sh[6:0], mosi_i};
        n++;
        if (n == 8) begin
            op = sh;
            if (sh != 8'h05 && st[0]) bad++;
            if (sh inside {8'h01, 8'h02, 8'h20, 8'hc7} && !st[1]) bad++;
            if (sh == 8'h06) st[1] = 1'b1;
        end
        if (n == 16 && op == 8'h01) wsr = sh;
        if (n > 16 && op == 8'h01) bad++;
    end
    always @(negedge sclk_i) if (!cs_n_i) begin
        b = (op == 8'h05) ? st : 8'(n / 8);
        miso_o = b[7 - n % 8];
    end
    always @(posedge cs_n_i) begin
        miso_o = ~miso_o;
        if (op inside {8'h01, 8'h02, 8'h20, 8'hc7}) st = 8'h01;
        else if (op == 8'h05) st[0] = 1'b0;
        if (op != 8'h05) sig = {op, n[7:0]};
    end
endmodule : sfs_flash_model
`default_nettype wire

// ===== tb/sfs_top_bench.sv
// Bench: boot, buffered program, erases, read, power chip byte.
// Assumes the flash model on select zero and a 4-byte boot fetch.
`timescale 1ns/1ps
`default_nettype none
module sfs_top_bench;
    logic sys_clk_i = 0, rst_i = 1, cmd_valid_i = 0, wr_valid_i = 0, serial_data_in_i;
    logic [23:0] cmd_addr_i = 0;
    logic [15:0] cmd_len_i = 0;
    logic [7:0] wr_data_i = 0, rd_data_o, pmic_rx_o, status_o, q[$];
    sfs_pkg::sfs_op_type cmd_op_i = sfs_pkg::SFS_OP_READ;
    logic cmd_ready_o, wr_ready_o, rd_valid_o, rd_boot_o, pmic_rx_valid_o, host_attn_o;
    logic serial_clk_out_o, serial_clk_out_oe_o, serial_data_out_o, serial_data_out_oe_o;
    logic boot_flash_select_n_o, boot_flash_select_n_oe_o, second_target_select_n_o;
    int fails = 0, samples_checked = 0, cyc = 0, t = 0;
    wire fcs = boot_flash_select_n_oe_o ? boot_flash_select_n_o : 1'b1;
    sfs_top #(.BOOT_BYTES(4)) u_sfs_top (.*);
    sfs_flash_model u_sfs_flash_model (.sclk_i(serial_clk_out_o), .cs_n_i(fcs),
        .mosi_i(serial_data_out_o), .miso_o(serial_data_in_i));
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (rd_valid_o === 1'b1) q.push_back(rd_data_o);
        if (++cyc == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    task check(input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task run(input sfs_pkg::sfs_op_type op, input logic [23:0] a, input logic [15:0] n);
        while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_len_i = n;
        cmd_valid_i = 1;
        @(negedge sys_clk_i) cmd_valid_i = 0;
        while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
        $display("test %0d done", ++t);
    endtask : run
    task report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3) @(negedge sys_clk_i);
        rst_i = 0;
        while (host_attn_o !== 1'b0) @(negedge sys_clk_i);
        check(q.size(), 4);
        foreach (q[i]) check(q[i], 8'h05 + i);
        check(u_sfs_flash_model.sig, 16'h0b48);
        check(u_sfs_flash_model.wsr, 8'h00);
        check(rd_boot_o, 1'b1);
        q.delete();
        for (int i = 0; i < 8; i++) begin
            wr_data_i = 8'(i);
            wr_valid_i = 1;
            @(negedge sys_clk_i);
        end
        wr_valid_i = 0;
        check(wr_ready_o, 1'b0);
        run(sfs_pkg::SFS_OP_PROGRAM, 24'h000100, 8);
        check(u_sfs_flash_model.sig, 16'h0260);
        check(status_o, 8'h00);
        run(sfs_pkg::SFS_OP_SECTOR_ERASE, 24'h001000, 0);
        check(u_sfs_flash_model.sig, 16'h2020);
        run(sfs_pkg::SFS_OP_CHIP_ERASE, 24'h000000, 0);
        check(u_sfs_flash_model.sig, 16'hc708);
        run(sfs_pkg::SFS_OP_READ, 24'h000200, 3);
        check(u_sfs_flash_model.sig, 16'h0b40);
        check(q.size(), 3);
        check(rd_boot_o, 1'b0);
        foreach (q[i]) check(q[i], 8'h05 + i);
        run(sfs_pkg::SFS_OP_PMIC, 24'h00003c, 0);
        check(u_sfs_flash_model.sig, 16'h0b40);
        check(pmic_rx_o, 8'hff);
        check(u_sfs_flash_model.bad, 0);
        report_and_stop();
    end
endmodule : sfs_top_bench
`default_nettype wire
